// ==== design/scnc_top.sv ====
// System clock selection, oscillator check, NMI and regulator control
`timescale 1ns/1ps
module scnc_top
  import scnc_pkg::*;
#(
  parameter int NPERIPH = 8,
  parameter int PLL_VCO_KHZ = 400000,
  parameter int PLL_R_DIV = 1,
  parameter int CRYSTAL_NUMBER_FIELD_BASE_KHZ = 1000,
  parameter int CRYSTAL_NUMBER_FIELD_STEP_KHZ = 512,
  parameter int LDO_STEP_MV = 50
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_src_lvl,
  input wire logic [1:0] i_cfg_oscsrc,
  input wire logic i_cfg_bypass,
  input wire logic i_cfg_pll_pwrdn,
  input wire logic [4:0] i_crystal_number_field,
  input wire logic i_ext_config_override,
  input wire logic [2:0] i_ext_oscsrc,
  input wire logic i_ext_bypass,
  input wire logic i_ext_pll_pwrdn,
  input wire logic i_pll_locked,
  input wire logic i_internal_fast_oscillator_enable,
  input wire logic i_osc_check_enable,
  input wire logic i_osc_failure_clear,
  input wire logic i_nmi_pin,
  input wire logic i_nmi_alt_request,
  input wire logic i_nmi_commit_ok,
  input wire logic i_nmi_ack,
  input wire logic [4:0] i_voltage_adjust_field,
  input wire logic [NPERIPH-1:0] i_periph_clk_en,
  output logic o_system_clock_out,
  output logic [2:0] o_active_source,
  output logic o_internal_fast_oscillator_enable,
  output logic o_pll_enable,
  output logic [15:0] o_pll_translation_reg,
  output logic o_pll_translation_busy,
  output logic o_adc_clk,
  output logic [NPERIPH-1:0] o_periph_clk,
  output logic o_osc_failure_flag,
  output logic o_system_reset,
  output logic o_nmi,
  output logic o_nmi_alt_selected,
  output logic [11:0] o_regulator_mv
);

  localparam int ADC_DIV = PLL_VCO_KHZ / ADC_KHZ;
  localparam int ADC_HALF = (ADC_DIV + 1) / 2;

  typedef struct packed {
    logic pll_en;
    logic nmi_alt_sel;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi;
    logic [4:0] lvl_prev;
    logic [1:0] div4_cnt;
    logic div4;
    scnc_fail_t fsm;
    logic fail_flag;
    logic force_internal_fast_oscillator;
    logic rst_out;
    logic [5:0] hold_cnt;
    logic [15:0] win_cnt;
    logic [15:0] edge_cnt;
    logic [4:0] crystal_number_field_prev;
    logic div_busy;
    logic [5:0] div_cnt;
    logic [32:0] div_rem;
    logic [31:0] div_quo;
    logic [31:0] div_den;
    logic [15:0] pll_f;
    logic [7:0] adc_cnt;
    logic adc_clk;
    logic [11:0] reg_mv;
    logic [NPERIPH-1:0] periph_en;
    logic [NPERIPH-1:0] periph_clk;
  } scnc_state_t;

  scnc_state_t st_ff;
  scnc_state_t nxt_st;

  logic [NUM_SRC-1:0] src_lvl;
  logic [2:0] eff_oscsrc;
  logic eff_bypass;
  logic eff_pwrdn;
  logic [2:0] req_sel;
  logic sw_clk;
  logic sw_gated;
  logic [2:0] sw_active;
  logic [4:0] rise;
  logic internal_fast_oscillator_rise;
  logic [31:0] crystal_number_field_khz;
  logic [32:0] div_trial;
  logic [31:0] mv_calc;

  // Source levels seen by the switch, with the divided internal oscillator added
  assign src_lvl = {st_ff.div4, i_src_lvl}; // [R11]
  assign rise = i_src_lvl & ~st_ff.lvl_prev;
  assign internal_fast_oscillator_rise = rise[SRC_INTERNAL_FAST_OSCILLATOR];

  // Extended configuration wins over the primary fields when overridden
  assign eff_oscsrc = i_ext_config_override ? i_ext_oscsrc : {1'b0, i_cfg_oscsrc}; // [R12]
  assign eff_bypass = i_ext_config_override ? i_ext_bypass : i_cfg_bypass; // [R12]
  assign eff_pwrdn = i_ext_config_override ? i_ext_pll_pwrdn : i_cfg_pll_pwrdn; // [R12]

  // Requested source; PLL only once enabled and locked, internal osc when forced
  always_comb begin
    unique case (eff_oscsrc)
      OSC_EXTERNAL_CRYSTAL_OSCILLATOR: req_sel = 3'(SRC_EXTERNAL_CRYSTAL_OSCILLATOR);
      OSC_INTERNAL_FAST_OSCILLATOR: req_sel = 3'(SRC_INTERNAL_FAST_OSCILLATOR);
      OSC_IOSC4: req_sel = 3'(SRC_IOSC4);
      OSC_LFOSC: req_sel = 3'(SRC_LFOSC);
      OSC_RTC: req_sel = 3'(SRC_RTC);
      default: req_sel = 3'(SRC_INTERNAL_FAST_OSCILLATOR);
    endcase
    if (!eff_bypass && st_ff.pll_en && i_pll_locked) begin
      req_sel = 3'(SRC_PLL); // [R11]
    end
    if (st_ff.force_internal_fast_oscillator) begin
      req_sel = 3'(SRC_INTERNAL_FAST_OSCILLATOR); // [R19]
    end
  end

  // Crystal frequency implied by the crystal number
  assign crystal_number_field_khz = 32'(CRYSTAL_NUMBER_FIELD_BASE_KHZ) + 32'(i_crystal_number_field) * 32'(CRYSTAL_NUMBER_FIELD_STEP_KHZ);
  assign div_trial = {st_ff.div_rem[31:0], st_ff.div_quo[31]} - {1'b0, st_ff.div_den};

  // Regulator level from the adjust field, clamped to the allowed span
  assign mv_calc = 32'(LDO_MIN_MV) + 32'(i_voltage_adjust_field) * 32'(LDO_STEP_MV);

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.lvl_prev = i_src_lvl;

    // PLL held off from reset until software powers it up
    nxt_st.pll_en = !eff_pwrdn; // [R18]

    // Internal oscillator divided by four
    if (internal_fast_oscillator_rise) begin
      nxt_st.div4_cnt = st_ff.div4_cnt + 2'h1;
      if (st_ff.div4_cnt == 2'(INTERNAL_FAST_OSCILLATOR_DIV / 2 - 1) || st_ff.div4_cnt == 2'(INTERNAL_FAST_OSCILLATOR_DIV - 1)) begin
        nxt_st.div4 = !st_ff.div4; // [R11]
      end
    end

    // NMI pin select changes only when the port commit allows it
    if (i_nmi_commit_ok) begin
      nxt_st.nmi_alt_sel = i_nmi_alt_request; // [R3]
    end
    nxt_st.nmi_s1 = i_nmi_pin; // [R20]
    nxt_st.nmi_s2 = st_ff.nmi_s1; // [R20]

    // Main oscillator frequency check over a fixed window
    if (i_osc_check_enable && st_ff.fsm == SCNC_RUN) begin
      if (st_ff.win_cnt == 16'(CHK_WINDOW_CYC - 1)) begin
        nxt_st.win_cnt = 16'h0000;
        nxt_st.edge_cnt = 16'h0000;
        if (st_ff.edge_cnt < 16'(CHK_MIN_EDGES) || st_ff.edge_cnt > 16'(CHK_MAX_EDGES)) begin
          nxt_st.fsm = SCNC_HOLD; // [R6]
          nxt_st.fail_flag = 1'b1; // [R7]
          nxt_st.force_internal_fast_oscillator = 1'b1; // [R19]
          nxt_st.rst_out = 1'b1; // [R5]
          nxt_st.hold_cnt = 6'h00;
        end
      end else begin
        nxt_st.win_cnt = st_ff.win_cnt + 16'h0001;
        if (rise[SRC_EXTERNAL_CRYSTAL_OSCILLATOR]) begin
          nxt_st.edge_cnt = st_ff.edge_cnt + 16'h0001;
        end
      end
    end else begin
      nxt_st.win_cnt = 16'h0000; // [R6]
      nxt_st.edge_cnt = 16'h0000;
    end

    // Failure sequence: reset for a fixed number of internal periods, then NMI
    unique case (st_ff.fsm)
      SCNC_RUN: begin
      end
      SCNC_HOLD: begin
        if (internal_fast_oscillator_rise) begin
          nxt_st.hold_cnt = st_ff.hold_cnt + 6'h01;
          if (st_ff.hold_cnt == 6'(FAIL_RST_PERIODS - 1)) begin
            nxt_st.rst_out = 1'b0; // [R19]
            nxt_st.fsm = SCNC_NMI; // [R5]
          end
        end
      end
      SCNC_NMI: begin
        if (i_nmi_ack) begin
          nxt_st.fsm = SCNC_RUN;
          nxt_st.force_internal_fast_oscillator = 1'b0;
        end
      end
      default: begin
        nxt_st.fsm = SCNC_RUN;
      end
    endcase

    // Failure flag is sticky; a new failure wins over the clear
    if (i_osc_failure_clear && !(nxt_st.fsm == SCNC_HOLD && st_ff.fsm == SCNC_RUN)) begin
      nxt_st.fail_flag = 1'b0; // [R7]
    end

    // NMI from the synchronised active-high pin or from the failure sequence
    nxt_st.nmi = (st_ff.nmi_alt_sel && st_ff.nmi_s2) || st_ff.fsm == SCNC_NMI; // [R1] [R4] [R5]

    // Retranslate the crystal number into the PLL multiplier on every change
    nxt_st.crystal_number_field_prev = i_crystal_number_field;
    if (i_crystal_number_field != st_ff.crystal_number_field_prev) begin
      nxt_st.div_busy = 1'b1; // [R16]
      nxt_st.div_cnt = 6'h00;
      nxt_st.div_rem = 33'h000000000;
      nxt_st.div_quo = 32'(PLL_VCO_KHZ) * 32'(PLL_R_DIV) + (crystal_number_field_khz >> 1); // [R17]
      nxt_st.div_den = crystal_number_field_khz;
    end else if (st_ff.div_busy) begin
      // One restoring division step per cycle, rounded to nearest
      if (div_trial[32]) begin
        nxt_st.div_rem = {st_ff.div_rem[31:0], st_ff.div_quo[31]};
        nxt_st.div_quo = {st_ff.div_quo[30:0], 1'b0};
      end else begin
        nxt_st.div_rem = div_trial;
        nxt_st.div_quo = {st_ff.div_quo[30:0], 1'b1};
      end
      nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
      if (st_ff.div_cnt == 6'h1F) begin
        nxt_st.div_busy = 1'b0;
        nxt_st.pll_f = div_trial[32] ? {st_ff.div_quo[14:0], 1'b0} : {st_ff.div_quo[14:0], 1'b1}; // [R17]
      end
    end

    // Converter clock from the PLL output, whatever the system source
    if (rise[SRC_PLL]) begin
      if (st_ff.adc_cnt == 8'(ADC_HALF - 1)) begin
        nxt_st.adc_cnt = 8'h00;
        nxt_st.adc_clk = !st_ff.adc_clk; // [R13]
      end else begin
        nxt_st.adc_cnt = st_ff.adc_cnt + 8'h01;
      end
    end

    // Regulator setting
    if (mv_calc > 32'(LDO_MAX_MV)) begin
      nxt_st.reg_mv = 12'(LDO_MAX_MV); // [R8]
    end else begin
      nxt_st.reg_mv = mv_calc[11:0]; // [R8]
    end

    // Peripheral enables change only while the system clock is low
    if (!sw_clk) begin
      nxt_st.periph_en = i_periph_clk_en; // [R14]
    end
    nxt_st.periph_clk = {NPERIPH{sw_clk}} & st_ff.periph_en; // [R14]
  end

  // State register; internal oscillator selected from reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_ff <= '0; // [R9] [R18]
      st_ff.fsm <= SCNC_RUN;
      st_ff.pll_f <= PLL_F_RESET;
      st_ff.reg_mv <= 12'(LDO_MIN_MV);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Glitch-free source switch
  scnc_clk_switch #(
    .NSRC(NUM_SRC)
  ) u_switch (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_src_lvl(src_lvl),
    .i_sel(req_sel),
    .o_clk(sw_clk),
    .o_active(sw_active),
    .o_gated(sw_gated)
  );

  // Outputs
  assign o_system_clock_out = sw_clk; // [R21]
  assign o_active_source = sw_active;
  assign o_internal_fast_oscillator_enable = i_internal_fast_oscillator_enable || st_ff.force_internal_fast_oscillator || sw_active == 3'(SRC_INTERNAL_FAST_OSCILLATOR) || sw_gated; // [R9] [R19]
  assign o_pll_enable = st_ff.pll_en; // [R18]
  assign o_pll_translation_reg = st_ff.pll_f; // [R17]
  assign o_pll_translation_busy = st_ff.div_busy;
  assign o_adc_clk = st_ff.adc_clk;
  assign o_periph_clk = st_ff.periph_clk;
  assign o_osc_failure_flag = st_ff.fail_flag; // [R2] [R7]
  assign o_system_reset = st_ff.rst_out; // [R5]
  assign o_nmi = st_ff.nmi;
  assign o_nmi_alt_selected = st_ff.nmi_alt_sel;
  assign o_regulator_mv = st_ff.reg_mv;

endmodule

// ==== design/scnc_pkg.sv ====
// Package of constants and types for the system clock and NMI control block
// Notes on behaviour
// [R1] NMI comes from pin or oscillator check
// [R2] Software reads failure flag to tell sources
// [R3] NMI pin selection only through commit protection
// [R4] NMI pin is active high level
// [R5] Oscillator failure resets, then enters NMI
// [R6] Checker runs only while its enable set
// [R7] Failure sets sticky flag in reset cause
// [R8] Regulator level follows adjust field, 2.25-2.75 V
// [R9] Internal oscillator runs from power-on reset
// [R10] Software stabilises crystal before switching to it
// [R11] Mux picks four oscillators, PLL, internal/4
// [R12] Override bit gives extended config precedence
// [R13] Converter clock divided down to 16 MHz
// [R14] Peripheral clocks individually gated from system clock
// [R15] Software keeps crystal within supported range
// [R16] Crystal field change retranslates PLL settings
// [R17] Translation readable, targets VCO within 1%
// [R18] PLL off after reset until enabled
// [R19] Failure forces internal osc, 32-period reset
// [R20] NMI pin passes two synchroniser flops
// [R21] Source switching never produces short pulses
package scnc_pkg;

  // Clock rate of i_clk
  localparam int CLK_KHZ = 25000;

  // Source indices at the switch inputs
  localparam int NUM_SRC = 6;
  localparam int SRC_INTERNAL_FAST_OSCILLATOR = 0;
  localparam int SRC_EXTERNAL_CRYSTAL_OSCILLATOR = 1;
  localparam int SRC_LFOSC = 2;
  localparam int SRC_RTC = 3;
  localparam int SRC_PLL = 4;
  localparam int SRC_IOSC4 = 5;

  // Oscillator source codes of the configuration fields
  localparam logic [2:0] OSC_EXTERNAL_CRYSTAL_OSCILLATOR = 3'h0;
  localparam logic [2:0] OSC_INTERNAL_FAST_OSCILLATOR = 3'h1;
  localparam logic [2:0] OSC_IOSC4 = 3'h2;
  localparam logic [2:0] OSC_LFOSC = 3'h3;
  localparam logic [2:0] OSC_RTC = 3'h7;

  // Oscillator check window and band of accepted crystal edges
  localparam int CHK_WINDOW_NS = 10000;
  localparam int CHK_WINDOW_CYC = (CHK_WINDOW_NS * CLK_KHZ) / 1000000;
  localparam int CHK_MIN_KHZ = 1000;
  localparam int CHK_MAX_KHZ = 16384;
  localparam int CHK_MIN_EDGES = (CHK_MIN_KHZ * CHK_WINDOW_NS) / 1000000;
  localparam int CHK_MAX_EDGES = (CHK_MAX_KHZ * CHK_WINDOW_NS + 999999) / 1000000;

  // Failure reset length in internal oscillator periods
  localparam int FAIL_RST_PERIODS = 32;

  // Converter clock target
  localparam int ADC_KHZ = 16000;

  // Regulator range in millivolts
  localparam int LDO_MIN_MV = 2250;
  localparam int LDO_MAX_MV = 2750;

  // Internal oscillator divider for the slow source
  localparam int INTERNAL_FAST_OSCILLATOR_DIV = 4;

  // Reset values
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [15:0] PLL_F_RESET = 16'h0000;

  // Oscillator failure sequence
  typedef enum logic [1:0] {
    SCNC_RUN = 2'b00,
    SCNC_HOLD = 2'b01,
    SCNC_NMI = 2'b11
  } scnc_fail_t;

endpackage

// ==== design/scnc_clk_switch.sv ====
// Glitch-free switch among sampled clock source levels
`timescale 1ns/1ps
module scnc_clk_switch
  import scnc_pkg::*;
#(
  parameter int NSRC = 6
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [NSRC-1:0] i_src_lvl,
  input wire logic [2:0] i_sel,
  output logic o_clk,
  output logic [2:0] o_active,
  output logic o_gated
);

  typedef struct packed {
    logic [2:0] cur;
    logic gated;
    logic clk;
  } scnc_sw_state_t;

  scnc_sw_state_t st_ff;
  scnc_sw_state_t nxt_st;

  // Gate off old source while it is low, then release new source while it is low
  always_comb begin
    nxt_st = st_ff;
    if (i_sel != st_ff.cur && !st_ff.gated) begin
      if (!i_src_lvl[st_ff.cur]) begin
        nxt_st.gated = 1'b1; // [R21]
      end
    end else if (st_ff.gated) begin
      if (!i_src_lvl[i_sel]) begin
        nxt_st.cur = i_sel; // [R21]
        nxt_st.gated = 1'b0;
      end
    end
    nxt_st.clk = nxt_st.gated ? 1'b0 : i_src_lvl[nxt_st.cur];
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_ff <= '{cur: SEL_RESET, gated: 1'b0, clk: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_clk = st_ff.clk;
  assign o_active = st_ff.cur;
  assign o_gated = st_ff.gated;

endmodule

// ==== verification/scnc_osc_model.sv ====
// Model of the oscillators and the interrupt pin on the far side of the block
`timescale 1ns/1ps
module scnc_osc_model (
  input wire logic i_clk,
  input wire logic i_crystal_number_field_run,
  input wire logic i_pin_req,
  output logic [4:0] o_src_lvl,
  output logic o_nmi_pin
);
  logic [3:0] cnt_ff = 4'h0;
  // Oscillators advance off the sampling edge
  always_ff @(negedge i_clk) begin
    cnt_ff <= cnt_ff + 4'h1;
  end
  // Crystal: 62 rising edges a check window, started before use, low when stopped
  assign o_src_lvl = {~cnt_ff[0], cnt_ff[3], cnt_ff[2], i_crystal_number_field_run & cnt_ff[1], cnt_ff[0]};
  // Pin driven high by an outside source to request the interrupt
  assign o_nmi_pin = i_pin_req;
endmodule

// ==== verification/scnc_checker.sv ====
// Concurrent checks on the ports of the clock and interrupt control block
`timescale 1ns/1ps
module scnc_checker
  import scnc_pkg::*;
#(
  parameter int LDO_STEP_MV = 50
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_src_lvl,
  input wire logic i_cfg_pll_pwrdn,
  input wire logic i_ext_config_override,
  input wire logic i_ext_pll_pwrdn,
  input wire logic i_osc_check_enable,
  input wire logic i_nmi_pin,
  input wire logic i_nmi_alt_request,
  input wire logic i_nmi_commit_ok,
  input wire logic [4:0] i_crystal_number_field,
  input wire logic [4:0] i_voltage_adjust_field,
  input wire logic o_pll_enable,
  input wire logic o_pll_translation_busy,
  input wire logic o_osc_failure_flag,
  input wire logic o_system_reset,
  input wire logic o_nmi,
  input wire logic o_nmi_alt_selected,
  input wire logic o_internal_fast_oscillator_enable,
  input wire logic [11:0] o_regulator_mv
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic internal_fast_oscillator_q_ff;
  logic [6:0] rise_ff;
  // Counts internal oscillator rising edges while the failure reset holds
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      internal_fast_oscillator_q_ff <= 1'b0;
      rise_ff <= 7'h00;
    end else begin
      internal_fast_oscillator_q_ff <= i_src_lvl[0];
      if (!o_system_reset) rise_ff <= 7'h00;
      else if (i_src_lvl[0] && !internal_fast_oscillator_q_ff) rise_ff <= rise_ff + 7'h01;
    end
  end
  // Expected regulator level in millivolts
  function automatic logic [11:0] mv_of(input logic [4:0] c);
    int v;
    v = LDO_MIN_MV + int'(c) * LDO_STEP_MV;
    mv_of = (v > LDO_MAX_MV) ? 12'(LDO_MAX_MV) : 12'(v);
  endfunction
  reg_level_a: assert property (!$past(i_reset) |-> o_regulator_mv == mv_of($past(i_voltage_adjust_field)))
    else $error("regulator level wrong");
  pll_on_a: assert property (!$past(i_reset) |->
    o_pll_enable == !$past(i_ext_config_override ? i_ext_pll_pwrdn : i_cfg_pll_pwrdn))
    else $error("pll enable wrong");
  alt_commit_a: assert property ($rose(o_nmi_alt_selected) |-> $past(i_nmi_commit_ok && i_nmi_alt_request))
    else $error("alternate pin taken without commit");
  nmi_level_a: assert property ((o_nmi_alt_selected && i_nmi_pin)[*5] |-> o_nmi)
    else $error("pin high gave no interrupt");
  nmi_sync_a: assert property (!o_nmi && !o_osc_failure_flag && !$past(i_nmi_pin, 2) && $rose(i_nmi_pin) |=> !o_nmi[*2])
    else $error("pin used before synchronising");
  fail_entry_a: assert property ($rose(o_osc_failure_flag) |-> o_system_reset && $past(i_osc_check_enable))
    else $error("failure flag without reset or check");
  fail_internal_fast_oscillator_a: assert property (o_system_reset |-> o_internal_fast_oscillator_enable)
    else $error("internal oscillator off in failure");
  hold_len_a: assert property ($fell(o_system_reset) |-> rise_ff inside {7'h20, 7'h21})
    else $error("failure reset length wrong");
  nmi_after_a: assert property ($fell(o_system_reset) |=> o_nmi)
    else $error("no interrupt after failure reset");
  xlat_busy_a: assert property ($changed(i_crystal_number_field) |=> o_pll_translation_busy)
    else $error("crystal change not translated");
endmodule
bind scnc_top scnc_checker #(.LDO_STEP_MV(LDO_STEP_MV)) chk_u (.*);

// ==== verification/test_system_clock_nmi_control.sv ====
// Self-checking testbench of the clock and interrupt control block
`timescale 1ns/1ps
module test_system_clock_nmi_control;
  import scnc_pkg::*;
  localparam int STEP_MV = 50;
  logic i_clk, i_reset, i_cfg_bypass, i_cfg_pll_pwrdn, i_ext_config_override, i_ext_bypass, i_ext_pll_pwrdn;
  logic i_pll_locked, i_internal_fast_oscillator_enable, i_osc_check_enable, i_osc_failure_clear, i_nmi_pin;
  logic i_nmi_alt_request, i_nmi_commit_ok, i_nmi_ack, crystal_number_field_run, pin_req;
  logic [4:0] i_src_lvl, i_crystal_number_field, i_voltage_adjust_field;
  logic [1:0] i_cfg_oscsrc;
  logic [2:0] i_ext_oscsrc, o_active_source;
  logic [7:0] i_periph_clk_en, o_periph_clk;
  logic o_system_clock_out, o_internal_fast_oscillator_enable, o_pll_enable, o_pll_translation_busy, o_adc_clk;
  logic o_osc_failure_flag, o_system_reset, o_nmi, o_nmi_alt_selected;
  logic [15:0] o_pll_translation_reg;
  logic [11:0] o_regulator_mv;
  int mismatches, n_checks, k, c0, c1;
  int vc[4] = '{0, 7, 10, 31};
  logic [2:0] srcmap[4] = '{3'h1, 3'h0, 3'h5, 3'h2};
  scnc_top #(.LDO_STEP_MV(STEP_MV)) dut_u (.*);
  scnc_osc_model osc_u (.i_clk(i_clk), .i_crystal_number_field_run(crystal_number_field_run), .i_pin_req(pin_req), .o_src_lvl(i_src_lvl),
    .o_nmi_pin(i_nmi_pin));
  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s: %h vs %h", $time, what, got, exp);
    end
  endtask
  function automatic logic hit(input int what, input logic [2:0] v);
    case (what)
      0: hit = o_pll_translation_busy === 1'b0;
      1: hit = o_system_reset === 1'b1;
      2: hit = o_system_reset === 1'b0;
      4: hit = o_adc_clk !== v[0];
      default: hit = o_active_source === v;
    endcase
  endfunction
  task automatic wait_until(input int what, input logic [2:0] v, input int lim);
    int i;
    for (i = 0; i < lim && !hit(what, v); i++) @(negedge i_clk);
    if (i == lim) begin
      mismatches++;
      $display("BAD %0t wait %0d timed out", $time, what);
      finish_test();
    end
  endtask
  // Expected translation: rounded multiplier for the crystal code
  function automatic logic [15:0] xl(input int c);
    int kz;
    kz = 1000 + c * 512;
    xl = 16'((400000 + kz / 2) / kz);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {i_cfg_bypass, i_cfg_pll_pwrdn, i_ext_bypass, i_ext_pll_pwrdn, i_reset} = 5'h1F;
    {i_ext_config_override, i_pll_locked, i_internal_fast_oscillator_enable, i_osc_check_enable, i_osc_failure_clear} = 5'h00;
    {i_nmi_alt_request, i_nmi_commit_ok, i_nmi_ack, crystal_number_field_run, pin_req} = 5'h00;
    i_cfg_oscsrc = 2'h1;
    i_ext_oscsrc = 3'h1;
    i_crystal_number_field = 5'h00;
    i_voltage_adjust_field = 5'h00;
    i_periph_clk_en = 8'h01;
    mismatches = 0;
    n_checks = 0;
    cyc(2);
    i_reset = 1'b0;
    cyc(1);
    check(o_regulator_mv, 16'(LDO_MIN_MV), "reg reset");
    check(o_active_source, 3'h0, "source reset");
    check({o_pll_enable, o_internal_fast_oscillator_enable}, 2'h1, "pll off");
    check(o_pll_translation_reg, 16'h0000, "xlat reset");
    for (k = 0; k < 4; k++) begin
      i_voltage_adjust_field = 5'(vc[k]);
      cyc(2);
      check(o_regulator_mv, 16'((LDO_MIN_MV + vc[k] * STEP_MV > LDO_MAX_MV) ? LDO_MAX_MV
        : LDO_MIN_MV + vc[k] * STEP_MV), "regulator");
    end
    i_crystal_number_field = 5'h05;
    cyc(2);
    wait_until(0, 3'h0, 60);
    check(o_pll_translation_reg, xl(5), "xlat");
    i_crystal_number_field = 5'h18;
    cyc(5);
    i_crystal_number_field = 5'h1F;
    cyc(2);
    wait_until(0, 3'h0, 60);
    check(o_pll_translation_reg, xl(31), "xlat restart");
    c0 = 0;
    c1 = 0;
    k = 0;
    // Internal oscillator toggles every cycle, so half of the samples are high
    repeat (16) begin
      cyc(1);
      c0 += int'(o_periph_clk[0] === 1'b1);
      c1 += int'(o_periph_clk[1] === 1'b1);
      k += int'(o_system_clock_out === 1'b1);
    end
    check(16'(c1), 16'h0000, "gated off");
    check(16'(c0), 16'h0008, "gated on");
    check(16'(k), 16'h0008, "system clock");
    pin_req = 1'b1;
    i_nmi_alt_request = 1'b1;
    cyc(8);
    check({o_nmi_alt_selected, o_nmi}, 2'h0, "no commit");
    i_nmi_commit_ok = 1'b1;
    cyc(8);
    check({o_nmi_alt_selected, o_nmi}, 2'h3, "pin nmi");
    pin_req = 1'b0;
    cyc(5);
    check(o_nmi, 1'b0, "pin low");
    crystal_number_field_run = 1'b1;
    cyc(20);
    for (k = 0; k < 4; k++) begin
      i_cfg_oscsrc = k[1:0];
      wait_until(3, srcmap[k], 60);
    end
    i_ext_config_override = 1'b1;
    i_ext_oscsrc = 3'h7;
    wait_until(3, 3'h3, 80);
    i_ext_oscsrc = 3'h1;
    {i_ext_bypass, i_ext_pll_pwrdn} = 2'h0;
    cyc(20);
    check({o_pll_enable, o_active_source}, 4'h8, "pll unlocked");
    i_pll_locked = 1'b1;
    wait_until(3, 3'h4, 60);
    wait_until(4, {2'h0, o_adc_clk}, 100);
    // PLL model rises every second cycle, so a half period is twice the rise count
    c0 = 0;
    for (k = int'(o_adc_clk); k == int'(o_adc_clk) && c0 < 40; c0++) cyc(1);
    check(16'(c0), 16'(2 * ((400000 / ADC_KHZ + 1) / 2)), "adc half period");
    {i_ext_bypass, i_ext_pll_pwrdn, i_ext_config_override} = 3'h6;
    i_cfg_oscsrc = 2'h0;
    wait_until(3, 3'h1, 60);
    check(o_internal_fast_oscillator_enable, 1'b0, "internal_fast_oscillator idle");
    i_osc_check_enable = 1'b1;
    cyc(600);
    check(o_osc_failure_flag, 1'b0, "good crystal");
    i_osc_check_enable = 1'b0;
    crystal_number_field_run = 1'b0;
    cyc(600);
    check(o_osc_failure_flag, 1'b0, "check off");
    i_osc_check_enable = 1'b1;
    wait_until(1, 3'h0, 600);
    check({o_osc_failure_flag, o_internal_fast_oscillator_enable}, 2'h3, "failure");
    wait_until(3, 3'h0, 10);
    i_osc_check_enable = 1'b0;
    wait_until(2, 3'h0, 100);
    cyc(2);
    check({o_nmi, o_osc_failure_flag}, 2'h3, "failure nmi");
    i_nmi_ack = 1'b1;
    i_osc_failure_clear = 1'b1;
    cyc(2);
    check({o_nmi, o_osc_failure_flag}, 2'h0, "ack and clear");
    finish_test();
  end
endmodule
